// *** rtl/stl_core.sv ***
// Torque limit selection, saturation timing, probe compensation and panel supervision
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns

// Operation
// - Position unit select picks ranges' unit
// - Torque limit select chooses limit sources
// - Second limit 0-500, clamped to motor
// - Effective limit is min with maximum torque
// - Initial display code 0-42, default 34
// - Display choice applies after power cycle
// - Probe one capture delayed by compensation
// - Probe two capture delayed by compensation
// - Panel lock one ignores panel keys
// - Protected class writable only at 102
// - Saturation signal after detection time elapses
// - Same time delays homing torque detection
// - Third limit applies during torque homing
module stl_core
   import stl_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF  // Cycles per millisecond
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] torque_cmd,
   input  wire logic [15:0] motor_max_torque,
   input  wire logic        probe1_pin,
   input  wire logic        probe2_pin,
   input  wire logic        panel_key_pin,
   input  wire logic        class7_wr_req,
   output logic             class7_wr_grant,
   output logic             panel_key_accept,
   output logic             probe1_capture,
   output logic             probe2_capture,
   output logic             torque_sat,
   output logic             homing_limit_reached,
   output stl_limits_t      torque_limits,
   output logic [1:0]       pos_unit_mode,
   output logic [5:0]       display_code,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Saturating store keeps each bounded field inside its legal range
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
      clamp = (v > lim) ? lim : v;
   endfunction

   // Smaller of two limits
   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction
   // Compensation steps to clock cycles, rounded up
   function automatic logic [13:0] comp_cycles(input logic [14:0] c);
      logic [31:0] t;
      t = (32'(c) * COMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      comp_cycles = t[13:0];
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]     pos_unit;   // Position unit select
      logic [1:0]     tl_src;     // Torque limit source
      logic [15:0]    tl1;        // First limit
      logic [15:0]    tl2;        // Second limit
      logic [15:0]    tl3;        // Homing limit
      logic [15:0]    fb_pos;     // Fieldbus positive limit
      logic [15:0]    fb_neg;     // Fieldbus negative limit
      logic [15:0]    max_tq;     // Maximum torque object
      logic [5:0]     disp_sel;   // Stored display choice
      logic [5:0]     disp_code;  // Display choice in force
      logic           booted;     // Display choice already taken
      logic [14:0]    p1_comp;    // Probe one compensation
      logic [14:0]    p2_comp;    // Probe two compensation
      logic           lock;       // Panel lock
      logic [15:0]    unlock;     // Protected class unlock code
      logic [12:0]    sat_time;   // Detection time in ms
      logic [1:0]     ctrl;       // Homing active, alarm enable
      logic [NEV-1:0] irq_st;     // Sticky events
      logic [NEV-1:0] irq_mask;   // Event enables
      logic [31:0]    rdata;      // Read data held for the access phase
      logic           err;        // Unmapped address seen at setup
      stl_limits_t    eff;        // Registered effective limits
      logic [13:0]    pre;        // Millisecond prescaler
      logic [12:0]    ms_cnt;     // Elapsed saturation in ms
      logic           sat_lvl;    // Saturation held long enough
      logic [1:0]     p1_sync;    // Probe one synchroniser
      logic           p1_prev;
      logic           p1_busy;
      logic [13:0]    p1_cnt;
      logic           p1_cap;
      logic [1:0]     p2_sync;    // Probe two synchroniser
      logic           p2_prev;
      logic           p2_busy;
      logic [13:0]    p2_cnt;
      logic           p2_cap;
      logic [1:0]     key_sync;   // Panel key synchroniser
      logic           key_prev;
      logic           key_ok;
      logic           sat_out;    // Saturation output
      logic           hom_out;    // Homing detection output
   } stl_state_t;

   stl_state_t s;       // Present state
   stl_state_t next_s;  // Next state

   // ----------------------------------------------------------------------
   // Combinational terms
   // ----------------------------------------------------------------------
   logic [15:0]    idx;         // Word index of the access
   logic           setup_ph;    // APB setup cycle
   logic           wr_ph;       // APB write taking effect
   logic [15:0]    wd;          // Low half of write data
   logic [15:0]    sel_pos;     // Selected positive limit
   logic [15:0]    sel_neg;     // Selected negative limit
   logic [15:0]    tq_mag;      // Magnitude of the command
   logic           saturated;   // Command at or beyond its limit
   logic           p1_edge;
   logic           p2_edge;
   logic           key_edge;
   logic [NEV-1:0] ev;          // Events of this cycle
   logic           mapped;
   logic [15:0]    rd;

   assign idx      = paddr[17:2];
   assign setup_ph = psel & ~penable;
   assign wr_ph    = psel & penable & pwrite & ~s.err;
   assign wd       = pwdata[15:0];
   assign p1_edge  = s.p1_sync[1] & ~s.p1_prev;
   assign p2_edge  = s.p2_sync[1] & ~s.p2_prev;
   assign key_edge = s.key_sync[1] & ~s.key_prev;

   // Read mux and decode; unaligned or unknown addresses are errors
   always_comb begin
      mapped = (paddr[1:0] == 2'b00);
      rd     = 16'h0000;
      unique case (idx)
         IDX_POS_UNIT: rd = {14'h0000, s.pos_unit};
         IDX_TL_SRC:   rd = {14'h0000, s.tl_src};
         IDX_TL1:      rd = s.tl1;
         IDX_TL2:      rd = s.tl2;
         IDX_TL3:      rd = s.tl3;
         IDX_DISP:     rd = {10'h000, s.disp_sel};
         IDX_P1_COMP:  rd = {1'b0, s.p1_comp};
         IDX_P2_COMP:  rd = {1'b0, s.p2_comp};
         IDX_LOCK:     rd = {15'h0000, s.lock};
         IDX_UNLOCK:   rd = s.unlock;
         IDX_SAT_TIME: rd = {3'h0, s.sat_time};
         IDX_IRQ_STAT: rd = {11'h000, s.irq_st};
         IDX_IRQ_MASK: rd = {11'h000, s.irq_mask};
         IDX_CTRL:     rd = {14'h0000, s.ctrl};
         IDX_STATUS:   rd = {12'h000, s.hom_out, s.sat_out, s.sat_lvl, s.lock};
         IDX_EFF_POS:  rd = s.eff.pos;
         IDX_EFF_NEG:  rd = s.eff.neg;
         IDX_FB_POS:   rd = s.fb_pos;
         IDX_FB_NEG:   rd = s.fb_neg;
         IDX_MAX_TQ:   rd = s.max_tq;
         default:      mapped = 1'b0;
      endcase
   end

   // Limit selection; homing by torque detection overrides both sides
   always_comb begin
      sel_pos = s.tl1;
      sel_neg = s.tl1;
      if (s.ctrl[0]) begin
         sel_pos = s.tl3;
         sel_neg = s.tl3;
      end else if (s.tl_src == 2'd1) begin
         sel_neg = min16(s.tl2, motor_max_torque);
      end else if (s.tl_src == 2'd2) begin
         sel_pos = s.fb_pos;
         sel_neg = s.fb_neg;
      end
   end

   // Negative command compares its magnitude with the negative limit
   assign tq_mag    = torque_cmd[15] ? 16'(-torque_cmd) : torque_cmd;
   assign saturated = tq_mag >= (torque_cmd[15] ? s.eff.neg : s.eff.pos);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s = s;
      ev     = '0;

      // Bus: read data and error captured in the setup cycle
      if (setup_ph) begin
         next_s.rdata = {16'h0000, rd};
         next_s.err   = ~mapped;
      end
      if (wr_ph) begin
         unique case (idx)
            IDX_POS_UNIT: next_s.pos_unit = 2'(clamp(wd, MAX_SEL2));
            IDX_TL_SRC:   next_s.tl_src = 2'(clamp(wd, MAX_SEL2));
            IDX_TL1:      next_s.tl1 = clamp(wd, MAX_PCT);
            IDX_TL2:      next_s.tl2 = clamp(wd, MAX_PCT);
            IDX_TL3:      next_s.tl3 = clamp(wd, MAX_PCT);
            IDX_DISP:     next_s.disp_sel = 6'(clamp(wd, MAX_DISP));
            IDX_P1_COMP:  next_s.p1_comp = 15'(clamp(wd, MAX_COMP));
            IDX_P2_COMP:  next_s.p2_comp = 15'(clamp(wd, MAX_COMP));
            IDX_LOCK:     next_s.lock = 1'(clamp(wd, MAX_LOCK));
            IDX_UNLOCK:   next_s.unlock = wd;
            IDX_SAT_TIME: next_s.sat_time = 13'(clamp(wd, MAX_SAT_TIME));
            IDX_IRQ_STAT: next_s.irq_st = s.irq_st & ~wd[NEV-1:0];
            IDX_IRQ_MASK: next_s.irq_mask = wd[NEV-1:0];
            IDX_CTRL:     next_s.ctrl = wd[1:0];
            IDX_FB_POS:   next_s.fb_pos = wd;
            IDX_FB_NEG:   next_s.fb_neg = wd;
            IDX_MAX_TQ:   next_s.max_tq = wd;
            default:      next_s.err = s.err;  // Read-only words ignore writes
         endcase
      end

      // Display choice taken once after reset; later writes wait for power-up
      if (!s.booted) begin
         next_s.booted    = 1'b1;
         next_s.disp_code = s.disp_sel;
      end

      // Effective limits never exceed the maximum torque object
      next_s.eff.pos = min16(sel_pos, s.max_tq);
      next_s.eff.neg = min16(sel_neg, s.max_tq);

      // Saturation timer; any drop below the limit starts it over
      if (!saturated) begin
         next_s.pre     = '0;
         next_s.ms_cnt  = '0;
         next_s.sat_lvl = 1'b0;
      end else if (s.ms_cnt >= s.sat_time) begin
         next_s.sat_lvl = 1'b1;
      end else if (s.pre == 14'(CYC_PER_MS - 1)) begin
         next_s.pre    = '0;
         next_s.ms_cnt = s.ms_cnt + 13'h0001;
      end else begin
         next_s.pre = s.pre + 14'h0001;
      end
      // Alarm enabled drives the signal; else the time serves torque homing
      next_s.sat_out = s.sat_lvl & s.ctrl[1];
      next_s.hom_out = s.sat_lvl & ~s.ctrl[1] & s.ctrl[0];
      ev[EV_SAT]  = next_s.sat_out & ~s.sat_out;
      ev[EV_HOME] = next_s.hom_out & ~s.hom_out;

      // Probe pins: synchronise, then delay the capture by the compensation
      next_s.p1_sync = {s.p1_sync[0], probe1_pin};
      next_s.p1_prev = s.p1_sync[1];
      next_s.p1_cap  = 1'b0;
      if (s.p1_busy) begin
         if (s.p1_cnt == 14'h0000) begin
            next_s.p1_cap  = 1'b1;
            next_s.p1_busy = 1'b0;
         end else begin
            next_s.p1_cnt = s.p1_cnt - 14'h0001;
         end
      end else if (p1_edge) begin
         next_s.p1_busy = 1'b1;  // Edges during a pending capture are dropped
         next_s.p1_cnt  = comp_cycles(s.p1_comp);
      end
      next_s.p2_sync = {s.p2_sync[0], probe2_pin};
      next_s.p2_prev = s.p2_sync[1];
      next_s.p2_cap  = 1'b0;
      if (s.p2_busy) begin
         if (s.p2_cnt == 14'h0000) begin
            next_s.p2_cap  = 1'b1;
            next_s.p2_busy = 1'b0;
         end else begin
            next_s.p2_cnt = s.p2_cnt - 14'h0001;
         end
      end else if (p2_edge) begin
         next_s.p2_busy = 1'b1;
         next_s.p2_cnt  = comp_cycles(s.p2_comp);
      end
      ev[EV_P1] = next_s.p1_cap;
      ev[EV_P2] = next_s.p2_cap;

      // Panel key: accepted only while unlocked
      next_s.key_sync = {s.key_sync[0], panel_key_pin};
      next_s.key_prev = s.key_sync[1];
      next_s.key_ok   = key_edge & ~s.lock;
      ev[EV_KEY]      = key_edge & s.lock;

      // Set wins over a clear in the same cycle
      next_s.irq_st = next_s.irq_st | ev;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s          <= '0;
         s.pos_unit <= RST_POS_UNIT[1:0];
         s.tl_src   <= RST_TL_SRC[1:0];
         s.tl1      <= RST_TL1;
         s.tl2      <= RST_TL2;
         s.tl3      <= RST_TL3;
         s.max_tq   <= RST_MAX_TQ;
         s.disp_sel <= RST_DISP[5:0];
         s.disp_code <= RST_DISP[5:0];
         s.sat_time <= RST_SAT_TIME[12:0];
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pready               = psel & penable;
   assign pslverr              = psel & penable & s.err;
   assign prdata               = s.rdata;
   assign class7_wr_grant      = class7_wr_req & (s.unlock == UNLOCK_CODE);
   assign panel_key_accept     = s.key_ok;
   assign probe1_capture       = s.p1_cap;
   assign probe2_capture       = s.p2_cap;
   assign torque_sat           = s.sat_out;
   assign homing_limit_reached = s.hom_out;
   assign torque_limits        = s.eff;
   assign pos_unit_mode        = s.pos_unit;
   assign display_code         = s.disp_code;
   assign irq                  = |(s.irq_st & s.irq_mask);

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_unit_range;
      pos_unit_mode <= 2'd2;
   endproperty
   a_unit_range: assert property (p_unit_range) else $error("unit select out of range");
   property p_src_zero;
      s.tl_src == 2'd0 && !s.ctrl[0] |=> torque_limits.pos == torque_limits.neg;
   endproperty
   a_src_zero: assert property (p_src_zero) else $error("source 0 limits differ");
   property p_tl2_motor;
      s.tl_src == 2'd1 && !s.ctrl[0] |=> torque_limits.neg <= $past(motor_max_torque);
   endproperty
   a_tl2_motor: assert property (p_tl2_motor) else $error("second limit above motor");
   property p_eff_max;
      torque_limits.pos <= $past(s.max_tq) && torque_limits.neg <= $past(s.max_tq);
   endproperty
   a_eff_max: assert property (p_eff_max) else $error("limit above maximum torque");
   property p_disp_range;
      display_code <= 6'd42;
   endproperty
   a_disp_range: assert property (p_disp_range) else $error("display code out of range");
   property p_disp_hold;
      s.booted |=> $stable(display_code);
   endproperty
   a_disp_hold: assert property (p_disp_hold) else $error("display changed after boot");
   property p_probe1;
      probe1_capture |-> $past(s.p1_busy) && $past(s.p1_cnt) == 14'h0000;
   endproperty
   a_probe1: assert property (p_probe1) else $error("probe one captured early");
   property p_probe2;
      probe2_capture |-> $past(s.p2_busy) && $past(s.p2_cnt) == 14'h0000;
   endproperty
   a_probe2: assert property (p_probe2) else $error("probe two captured early");
   property p_lock;
      panel_key_accept |-> !$past(s.lock);
   endproperty
   a_lock: assert property (p_lock) else $error("key accepted while locked");
   property p_grant;
      class7_wr_grant |-> s.unlock == 16'h0066;
   endproperty
   a_grant: assert property (p_grant) else $error("grant without unlock code");
   property p_sat_time;
      $rose(s.sat_lvl) |-> $past(s.ms_cnt) >= $past(s.sat_time) && $past(saturated);
   endproperty
   a_sat_time: assert property (p_sat_time) else $error("saturation flagged too soon");
   property p_homing;
      homing_limit_reached |-> !torque_sat && $past(s.sat_lvl) && $past(!s.ctrl[1]);
   endproperty
   a_homing: assert property (p_homing) else $error("homing flag with alarm on");
   property p_tl3;
      s.ctrl[0] |=> torque_limits.pos <= $past(s.tl3) && torque_limits.neg <= $past(s.tl3);
   endproperty
   a_tl3: assert property (p_tl3) else $error("homing limit not applied");
   property p_restart;
      !saturated |=> s.ms_cnt == 13'h0000 && !s.sat_lvl ##1 !torque_sat;
   endproperty
   a_restart: assert property (p_restart) else $error("timer kept running");
endmodule

// *** rtl/stl_pkg.sv ***
// Package: register map, field limits, reset values and types of the torque limit block
package stl_pkg;

   // ----------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [15:0] IDX_POS_UNIT   = 16'h2520;  // position_unit_select
   localparam logic [15:0] IDX_TL_SRC     = 16'h2521;  // torque_limit_source_select
   localparam logic [15:0] IDX_TL2        = 16'h2522;  // second_torque_limit
   localparam logic [15:0] IDX_DISP       = 16'h2528;  // initial_display_select
   localparam logic [15:0] IDX_P1_COMP    = 16'h2533;  // probe_one_time_comp
   localparam logic [15:0] IDX_P2_COMP    = 16'h2534;  // probe_two_time_comp
   localparam logic [15:0] IDX_LOCK       = 16'h2535;  // panel_lock
   localparam logic [15:0] IDX_UNLOCK     = 16'h2536;  // protected_class_unlock
   localparam logic [15:0] IDX_SAT_TIME   = 16'h2537;  // saturation_detect_time
   localparam logic [15:0] IDX_TL3        = 16'h2539;  // homing_torque_limit
   localparam logic [15:0] IDX_TL1        = 16'h2013;  // first_torque_limit
   localparam logic [15:0] IDX_IRQ_STAT   = 16'h2540;  // Sticky event flags, write one to clear
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h2541;  // Interrupt enables
   localparam logic [15:0] IDX_CTRL       = 16'h2542;  // bit0 homing active, bit1 alarm enable
   localparam logic [15:0] IDX_STATUS     = 16'h2543;  // Live status, read only
   localparam logic [15:0] IDX_EFF_POS    = 16'h2544;  // Effective positive limit, read only
   localparam logic [15:0] IDX_EFF_NEG    = 16'h2545;  // Effective negative limit, read only
   localparam logic [15:0] IDX_FB_POS     = 16'h60e0;  // Fieldbus positive limit object
   localparam logic [15:0] IDX_FB_NEG     = 16'h60e1;  // Fieldbus negative limit object
   localparam logic [15:0] IDX_MAX_TQ     = 16'h6072;  // Maximum torque object

   // ----------------------------------------------------------------------
   // Reset values and upper bounds of the fields
   // ----------------------------------------------------------------------
   localparam logic [15:0] RST_POS_UNIT   = 16'h0002;
   localparam logic [15:0] RST_TL_SRC     = 16'h0000;
   localparam logic [15:0] RST_TL2        = 16'h012c;
   localparam logic [15:0] RST_DISP       = 16'h0022;
   localparam logic [15:0] RST_SAT_TIME   = 16'h01f4;
   localparam logic [15:0] RST_TL3        = 16'h0050;
   localparam logic [15:0] RST_TL1        = 16'h012c;
   localparam logic [15:0] RST_MAX_TQ     = 16'h01f4;
   localparam logic [15:0] MAX_SEL2       = 16'h0002;  // Three-way selectors
   localparam logic [15:0] MAX_PCT        = 16'h01f4;  // 500 percent
   localparam logic [15:0] MAX_DISP       = 16'h002a;  // Display code 42
   localparam logic [15:0] MAX_COMP       = 16'h7fff;  // 32767 steps
   localparam logic [15:0] MAX_LOCK       = 16'h0001;
   localparam logic [15:0] MAX_SAT_TIME   = 16'h1388;  // 5000 ms
   localparam logic [15:0] UNLOCK_CODE    = 16'h0066;  // 102 opens the protected class

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int COMP_STEP_NS   = 25;
   localparam int MS_NS          = 1000000;
   localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;  // 10000, top parameter

   // ----------------------------------------------------------------------
   // Event bits and types
   // ----------------------------------------------------------------------
   localparam int EV_SAT  = 0;  // Saturation signal rose
   localparam int EV_HOME = 1;  // Homing torque detection reached
   localparam int EV_P1   = 2;  // Probe one captured
   localparam int EV_P2   = 3;  // Probe two captured
   localparam int EV_KEY  = 4;  // Panel key refused while locked
   localparam int NEV     = 5;

   typedef struct packed {
      logic [15:0] pos;  // Effective positive torque limit
      logic [15:0] neg;  // Effective negative torque limit
   } stl_limits_t;

endpackage

// *** sim/stl_host.sv ***
// APB master model of the motion controller side
`timescale 1ns/1ns
module stl_host (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [17:0]      paddr,
   output logic [31:0]      pwdata
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // One word transfer; a hang leaves unknown status so the caller fails it
   task automatic xfer(input logic w, input logic [15:0] i, input logic [15:0] d,
                       output logic [31:0] q, output logic e);
      q = 'x;
      e = 1'bx;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            q = prdata;
            e = pslverr;
            break;
         end
      end
      {psel, penable} <= 2'b00;
      pwdata <= ~pwdata;  // Released data must not look valid
   endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the torque limit block
`timescale 1ns/1ns
module tb;
   import stl_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, seed = 32'd84196;
   logic [15:0] tcmd = '0, mmax = '0, v [6], p, q;
   logic p1 = 0, p2 = 0, key = 0, req = 0, grant, acc_k, cap1, cap2, sat, hom;
   logic [1:0] unit;
   logic [5:0] disp;
   stl_limits_t lim;
   int fails = 0, n_tests = 0, n, k, j;
   localparam logic [15:0] RI [12] = '{IDX_POS_UNIT, IDX_TL_SRC, IDX_TL2, IDX_DISP,
      IDX_P1_COMP, IDX_P2_COMP, IDX_LOCK, IDX_UNLOCK, IDX_SAT_TIME, IDX_TL3, IDX_TL1, IDX_MAX_TQ};
   localparam logic [15:0] RV [12] = '{RST_POS_UNIT, 16'h0, RST_TL2, RST_DISP, 16'h0, 16'h0,
      16'h0, 16'h0, RST_SAT_TIME, RST_TL3, RST_TL1, RST_MAX_TQ};
   localparam logic [15:0] WI [5] = '{IDX_TL1, IDX_TL2, IDX_FB_POS, IDX_FB_NEG, IDX_MAX_TQ};
   always #50 pclk = ~pclk;
   stl_host host_inst (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   stl_core #(.CYC_PER_MS(4)) stl_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .torque_cmd(tcmd), .motor_max_torque(mmax),
      .probe1_pin(p1), .probe2_pin(p2), .panel_key_pin(key), .class7_wr_req(req),
      .class7_wr_grant(grant), .panel_key_accept(acc_k), .probe1_capture(cap1),
      .probe2_capture(cap2), .torque_sat(sat), .homing_limit_reached(hom),
      .torque_limits(lim), .pos_unit_mode(unit), .display_code(disp), .irq(irq));
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return 16'(seed % 501);
   endfunction
   function automatic logic [15:0] mn(input logic [15:0] a, b);
      return (a < b) ? a : b;
   endfunction
   task automatic ck(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic io(input logic w, input logic [15:0] i, d, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      host_inst.xfer(w, i, d, r, e);
      ck("pslverr", 32'(e), 32'(xe));
      if (!w) ck("prdata", r, x);
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge pclk);
   endtask
   task automatic wrap_up();
      $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #3000000;
      fails++;
      wrap_up();
   end
   // Main sequence; each waiting loop is bounded and judged afterwards
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 12; k++) io(0, RI[k], 0, RV[k], 0);
      ck("unit", 32'(unit), 32'd2);
      io(1, IDX_POS_UNIT, 16'h1, 0, 0);
      tick(1);
      ck("unit", 32'(unit), 32'd1);
      io(0, 16'h2529, 0, 0, 1);
      io(1, IDX_TL2, 16'hffff, 0, 0);
      io(0, IDX_TL2, 0, 32'(MAX_PCT), 0);
      io(1, IDX_DISP, 16'h5, 0, 0);
      tick(2);
      ck("display", 32'(disp), 32'd34);
      $display("test registers done");
      for (k = 0; k < 3; k++) begin
         for (j = 0; j < 6; j++) v[j] = rnd();
         if (k == 1) v[5] = v[1] >> 1;  // Motor clamp must bite
         @(posedge pclk) mmax <= v[5];
         for (j = 0; j < 5; j++) io(1, WI[j], v[j], 0, 0);
         io(1, IDX_TL_SRC, 16'(k), 0, 0);
         tick(3);
         p = mn(k == 2 ? v[2] : v[0], v[4]);
         q = mn(k == 0 ? v[0] : (k == 1 ? mn(v[1], v[5]) : v[3]), v[4]);
         ck("limits", lim, {p, q});
      end
      $display("test limits done");
      io(1, IDX_TL_SRC, 0, 0, 0);
      io(1, IDX_TL1, 16'd100, 0, 0);
      io(1, IDX_MAX_TQ, 16'd500, 0, 0);
      io(1, IDX_SAT_TIME, 16'd2, 0, 0);
      io(1, IDX_IRQ_MASK, 16'h1, 0, 0);
      io(1, IDX_CTRL, 16'h2, 0, 0);
      @(posedge pclk) tcmd <= 16'd100;
      tick(5);
      @(posedge pclk) tcmd <= 16'd99;
      @(posedge pclk) tcmd <= 16'd100;
      tick(5);
      ck("sat restart", 32'(sat), 0);
      for (n = 0; n < 20 && sat !== 1'b1; n++) tick(1);
      ck("sat", 32'(sat), 1);
      ck("irq", 32'(irq), 1);
      @(posedge pclk) tcmd <= 16'd0;
      tick(3);
      ck("sat drop", 32'(sat), 0);
      io(1, IDX_IRQ_STAT, 16'h1, 0, 0);
      tick(1);
      ck("irq clear", 32'(irq), 0);
      io(1, IDX_CTRL, 16'h1, 0, 0);
      tick(3);
      ck("homing limits", lim, {16'd80, 16'd80});
      @(posedge pclk) tcmd <= 16'hffb0;
      for (n = 0; n < 20 && hom !== 1'b1; n++) tick(1);
      ck("homing", 32'({hom, sat}), 32'h2);
      @(posedge pclk) tcmd <= 16'd0;
      $display("test saturation done");
      req <= 1'b1;
      for (k = 0; k < 3; k++) begin
         io(1, IDX_UNLOCK, k == 1 ? 16'd102 : 16'(101 - k), 0, 0);
         tick(1);
         ck("grant", 32'(grant), 32'(k == 1));
      end
      for (k = 0; k < 2; k++) begin
         io(1, IDX_LOCK, 16'(1 - k), 0, 0);
         @(posedge pclk) key <= 1'b1;
         n = 0;
         repeat (8) begin
            @(negedge pclk);
            if (acc_k === 1'b1) n++;
         end
         @(posedge pclk) key <= 1'b0;
         ck("key", 32'(n), 32'(k));
      end
      for (k = 0; k < 2; k++) begin
         v[0] = rnd() % 16;
         io(1, k ? IDX_P2_COMP : IDX_P1_COMP, v[0], 0, 0);
         @(posedge pclk) {p2, p1} <= k ? 2'b10 : 2'b01;
         for (n = 0; n < 40 && (k ? cap2 : cap1) !== 1'b1; n++) tick(1);
         @(posedge pclk) {p2, p1} <= 2'b00;
         ck("capture delay", 32'(n),
            32'((v[0] * COMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 5));
      end
      $display("test panel and probes done");
      wrap_up();
   end
endmodule
